// >>> src/flash_host.v
// Operation
// R01 - Chip select low frames each command
// R02 - Bytes sent MSB first, sampled rising
// R03 - Device output idle while host sends
// R04 - Read data shifted MSB first, falling
// R05 - Idle clock level picks mode 0/3
// R06 - Read: opcode plus three address bytes
// R07 - Fast read adds one dummy byte
// R08 - Normal read data follows fourth byte
// R09 - Fast read data follows fifth byte
// R10 - Address increments and wraps during read
// R11 - Raising chip select ends read
// R12 - Upper six address bits ignored
// R13 - Non-read commands end on byte boundary
// R14 - Erase opcodes with address or alone
// R15 - Erase regions of 4K or 64K
// R16 - Page program up to 256 bytes; ndata_ff allows up to 511 and is not checked
// R17 - Status read/write frame lengths
// R18 - Two identification read frames
// R19 - Power-down exit shares ID2 opcode
// R20 - Hold low suspends serial transfer
// R21 - Write-protect pin gates status protect
// R22 - Program and erase time limits
// R23 - Write enable and disable opcodes
// R24 - Power-down ignored during writes
// R25 - Busy bit shows internal write
// R26 - Enable latch cleared after writes
// R27 - Poll busy before next command
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_consts.vh"
module flash_host (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         cs_n_ff,
    output reg         sclk_ff,
    output reg         mosi_ff,
    input  wire        miso,
    output reg         wp_n_ff,
    output reg         hold_n_ff
);
    // ------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------
    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_SHIFT = 4'b0010;
    localparam [3:0] ST_LOAD  = 4'b0100;
    localparam [3:0] ST_END   = 4'b1000;

    reg  [3:0]  state_ff;
    reg  [7:0]  op_ff;
    reg  [23:0] addr_ff;
    reg  [31:0] wdata_ff;
    reg  [31:0] rdata_ff;
    reg  [8:0]  ndata_ff;
    reg         mode3_ff;
    reg         done_ff;
    reg  [7:0]  div_ff;
    reg  [7:0]  shreg_ff;
    reg  [2:0]  bit_ff;
    reg  [3:0]  hdr_ff;
    reg  [8:0]  dcnt_ff;
    reg  [3:0]  hdr_len_ff;
    reg         is_in_ff;
    reg         miso_m_ff;
    reg         miso_s_ff;
    reg         aw_hold_ff;
    reg         w_hold_ff;
    reg  [7:0]  awa_ff;
    reg  [31:0] wd_ff;
    wire        tick;

    // Header length per opcode (opcode + address/dummy bytes)
    function [3:0] hdr_len;
        input [7:0] op;
        begin
            case (op)
                `OP_READ, `OP_PP, `OP_SSE_A, `OP_SSE_B,
                `OP_SE, `OP_ID2: hdr_len = 4'h4; // R06 R14 R16 R18 R19
                `OP_FAST_READ:   hdr_len = 4'h5; // R07
                default:      hdr_len = 4'h1; // R14 R17 R23 R24
            endcase
        end
    endfunction

    // Opcodes whose data phase is read from the device
    function is_input;
        input [7:0] op;
        begin
            is_input = (op == `OP_READ) || (op == `OP_FAST_READ) ||
                       (op == `OP_RDSR) || (op == `OP_ID1) ||
                       (op == `OP_ID2);
        end
    endfunction

    // Byte to send for header index h
    function [7:0] hdr_byte;
        input [3:0]  h;
        input [7:0]  op;
        input [23:0] a;
        begin
            case (h)
                4'h0:    hdr_byte = op;
                4'h1:    hdr_byte = a[23:16];
                4'h2:    hdr_byte = a[15:8];
                4'h3:    hdr_byte = a[7:0];
                default: hdr_byte = 8'h00; // R07
            endcase
        end
    endfunction

    // Next byte to send: header first, then write data low byte first
    wire [7:0] load_byte = (hdr_ff < hdr_len_ff) ?
                           hdr_byte(hdr_ff, op_ff, addr_ff) :
                           wdata_ff[8*dcnt_ff[1:0] +: 8];

    sclk_divider u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (state_ff == ST_SHIFT),
        .half_div (div_ff),
        .tick_ff  (tick)
    );

    // ------------------------------------------------------------
    // Serial input synchroniser; needs a divider of 2 or more
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            miso_m_ff <= 1'b0;
            miso_s_ff <= 1'b0;
        end else begin
            miso_m_ff <= miso;
            miso_s_ff <= miso_m_ff;
        end
    end

    // ------------------------------------------------------------
    // Control bus write channel
    // ------------------------------------------------------------
    wire do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
    wire start    = do_write && awa_ff == `REG_CTRL &&
                    wd_ff[`CTRL_GO_BIT] && state_ff == ST_IDLE;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BUS_OKAY;
            aw_hold_ff    <= 1'b0;
            w_hold_ff     <= 1'b0;
            awa_ff        <= 8'h00;
            wd_ff         <= 32'h00000000;
            addr_ff       <= 24'h000000;
            wdata_ff      <= 32'h00000000;
            div_ff        <= `DIV_RESET;
            wp_n_ff       <= 1'b1;
            hold_n_ff     <= 1'b1;
            op_ff         <= 8'h00;
            ndata_ff      <= 9'h000;
            mode3_ff      <= 1'b0;
        end else begin
            s_axi_awready <= !aw_hold_ff && s_axi_awvalid &&
                             !s_axi_awready;
            s_axi_wready  <= !w_hold_ff && s_axi_wvalid &&
                             !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_ff <= 1'b1;
                awa_ff     <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_ff <= 1'b1;
                wd_ff     <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (do_write) begin
                aw_hold_ff   <= 1'b0;
                w_hold_ff    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `BUS_OKAY;
                case (awa_ff)
                    `REG_CTRL: begin
                        if (start) begin
                            op_ff    <= wd_ff[`CTRL_OP_MSB:`CTRL_OP_LSB];
                            ndata_ff <= wd_ff[`CTRL_NDATA_MSB:
                                              `CTRL_NDATA_LSB];
                            mode3_ff <= wd_ff[`CTRL_MODE3_BIT]; // R05
                        end
                    end
                    `REG_ADDR:   addr_ff  <= wd_ff[23:0] & `ADDR_MASK; // R12
                    `REG_WDATA:  wdata_ff <= wd_ff;
                    `REG_STATUS: begin
                        wp_n_ff   <= wd_ff[`STAT_WP_BIT];   // R21
                        hold_n_ff <= wd_ff[`STAT_HOLD_BIT]; // R20
                    end
                    `REG_DIV:    div_ff   <= wd_ff[7:0];
                    default:     s_axi_bresp <= `BUS_SLVERR;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Control bus read channel
    // ------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `BUS_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready &&
                             !s_axi_rvalid;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `BUS_OKAY;
                case (s_axi_araddr)
                    `REG_CTRL:   s_axi_rdata <= {7'h00, ndata_ff,
                                                 op_ff, 6'h00,
                                                 mode3_ff, 1'b0};
                    `REG_ADDR:   s_axi_rdata <= {8'h00, addr_ff};
                    `REG_WDATA:  s_axi_rdata <= wdata_ff;
                    `REG_RDATA:  s_axi_rdata <= rdata_ff;
                    `REG_STATUS: s_axi_rdata <= {28'h0000000,
                                                 hold_n_ff, wp_n_ff,
                                                 done_ff,
                                                 state_ff != ST_IDLE};
                    `REG_DIV:    s_axi_rdata <= {24'h000000, div_ff};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `BUS_SLVERR;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------
    // Each tick toggles sclk while hold_n_ff is high; rising half samples, byte ends on 8th rise
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_ff   <= ST_IDLE;
            cs_n_ff    <= 1'b1;
            sclk_ff    <= 1'b0;
            mosi_ff    <= 1'b0;
            shreg_ff   <= 8'h00;
            bit_ff     <= 3'h0;
            hdr_ff     <= 4'h0;
            hdr_len_ff <= 4'h1;
            dcnt_ff    <= 9'h000;
            is_in_ff   <= 1'b0;
            rdata_ff   <= 32'h00000000;
            done_ff    <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    sclk_ff <= mode3_ff; // R05
                    if (start) begin
                        done_ff  <= 1'b0;
                        sclk_ff  <= wd_ff[`CTRL_MODE3_BIT];
                        hdr_ff   <= 4'h0;
                        dcnt_ff  <= 9'h000;
                        state_ff <= ST_LOAD;
                        hdr_len_ff <= hdr_len(
                            wd_ff[`CTRL_OP_MSB:`CTRL_OP_LSB]);
                        is_in_ff <= is_input(
                            wd_ff[`CTRL_OP_MSB:`CTRL_OP_LSB]);
                    end
                end
                ST_LOAD: begin
                    cs_n_ff  <= 1'b0; // R01
                    shreg_ff <= load_byte; // R16
                    if (!sclk_ff)
                        mosi_ff <= load_byte[7]; // R02
                    bit_ff   <= 3'h7;
                    state_ff <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (tick && hold_n_ff) begin // R20
                        sclk_ff <= !sclk_ff;
                        if (sclk_ff) begin
                            mosi_ff <= shreg_ff[7]; // R02
                        end else begin
                            shreg_ff <= {shreg_ff[6:0], miso_s_ff}; // R04
                            bit_ff   <= bit_ff - 3'h1;
                            if (bit_ff == 3'h0) begin
                                if (hdr_ff >= hdr_len_ff) begin
                                    if (is_in_ff)
                                        rdata_ff <= {rdata_ff[23:0],
                                                     shreg_ff[6:0],
                                                     miso_s_ff}; // R10
                                    dcnt_ff <= dcnt_ff + 9'h001;
                                end else
                                    hdr_ff <= hdr_ff + 4'h1; // R08 R09
                                state_ff <= ST_END;
                            end
                        end
                    end
                end
                ST_END: begin
                    // Stop only on a whole byte
                    if (hdr_ff < hdr_len_ff ||
                        dcnt_ff < ndata_ff) // R13 R17
                        state_ff <= ST_LOAD;
                    else begin
                        cs_n_ff  <= 1'b1; // R11 R13
                        done_ff  <= 1'b1; // R27
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // flash_host
`default_nettype wire

// >>> src/flash_host_consts.vh
`ifndef FLASH_HOST_CONSTS_VH
`define FLASH_HOST_CONSTS_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses on the control bus)
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_WDATA       8'h08
`define REG_RDATA       8'h0C
`define REG_STATUS      8'h10
`define REG_DIV         8'h14
// Control register fields
`define CTRL_GO_BIT     0
`define CTRL_MODE3_BIT  1
`define CTRL_OP_LSB     8
`define CTRL_OP_MSB     15
`define CTRL_NDATA_LSB  16
`define CTRL_NDATA_MSB  24
// Status register fields
`define STAT_BUSY_BIT   0
`define STAT_DONE_BIT   1
`define STAT_WP_BIT     2
`define STAT_HOLD_BIT   3
// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define OP_READ         8'h03
`define OP_FAST_READ    8'h0B
`define OP_SSE_A        8'hD7
`define OP_SSE_B        8'h20
`define OP_SE           8'hD8
`define OP_CE           8'hC7
`define OP_PP           8'h02
`define OP_WREN         8'h06
`define OP_WRDI         8'h04
`define OP_PDOWN        8'hB9
`define OP_RDSR         8'h05
`define OP_WRSR         8'h01
`define OP_ID1          8'h9F
`define OP_ID2          8'hAB
// ----------------------------------------------------------------
// Field sizes and reset values
// ----------------------------------------------------------------
`define ADDR_MASK       24'h03FFFF
`define PAGE_BYTES      9'h100
`define DIV_RESET       8'h01
`define BUS_OKAY        2'h0
`define BUS_SLVERR      2'h2
`endif

// >>> src/sclk_divider.v
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Serial clock enable divider
// ----------------------------------------------------------------
module sclk_divider (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire       run,
    input  wire [7:0] half_div,
    output reg        tick_ff
);
    reg [7:0] cnt_ff;

    // One-cycle pulse every half_div+1 cycles while running
    always @(posedge aclk) begin
        if (!aresetn || !run) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b0;
        end else if (cnt_ff >= half_div) begin
            cnt_ff  <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end
endmodule // sclk_divider
`default_nettype wire

// >>> tb/flash_host_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Port checker for the flash host
// ------------------------------------------
module flash_host_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic cs_n_ff,
    input wire logic sclk_ff,
    input wire logic mosi_ff,
    input wire logic wp_n_ff,
    input wire logic hold_n_ff
);
    logic cs_d_ff;
    logic mode_ff;
    // Clock level seen as a frame opens
    always @(posedge aclk) begin
        cs_d_ff <= cs_n_ff;
        if (cs_d_ff && !cs_n_ff)
            mode_ff <= sclk_ff;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_idle: assert property ($rose(aresetn) |-> cs_n_ff && wp_n_ff && hold_n_ff)
        else $error("pins not idle after reset");
    a_mode_kept: assert property ($rose(cs_n_ff) |=> sclk_ff == mode_ff)
        else $error("clock idle level changed in frame");
    a_cs_gap: assert property ($rose(cs_n_ff) |=> cs_n_ff)
        else $error("select reopened at once");
    a_mosi_steady: assert property (!cs_n_ff && $rose(sclk_ff) |-> $stable(mosi_ff))
        else $error("data moved at rising clock");
    a_hold_freeze: assert property (!hold_n_ff && !$past(hold_n_ff) |-> $stable(sclk_ff))
        else $error("clock ran while held");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
        else $error("write response missing");
    a_write_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
endmodule // flash_host_checker
bind flash_host flash_host_checker u_chk (.*);
`default_nettype wire

// >>> tb/flash_model.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------
// Behavioural serial flash device
// ------------------------------------------
module flash_model #(
    parameter logic [7:0] STAT_VAL = 8'h5A, // Arbitrary
    parameter logic [7:0] ID_VAL   = 8'hA5  // Arbitrary identity value
) (
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic hold_n,
    output var logic  miso
);
    logic [7:0]  sh_ff, op_ff, last_op, last_byte, b;
    logic [23:0] adr_ff;
    logic        rd_ff;
    logic        wen_ff = 1'b0;
    int          nb_ff, hdr, last_nb, k;
    initial miso = 1'b0;
    // Byte stored at a location
    function automatic logic [7:0] m(input logic [17:0] a);
        return a[7:0] ^ {2'b00, a[17:12]};
    endfunction
    // Selection clears the frame
    always @(negedge cs_n) begin
        nb_ff = 0;
        rd_ff = 1'b0;
        miso = ~miso;
    end
    // Deselection keeps only whole commands
    always @(posedge cs_n) begin
        miso = ~miso;
        if (nb_ff % 8 == 0 && !rd_ff) begin
            last_op = op_ff;
            last_nb = nb_ff / 8;
            if (op_ff == 8'h06 && last_nb == 1)
                wen_ff = 1'b1;
            else if (op_ff inside {8'h04, 8'h01, 8'h02, 8'hC7, 8'hD7,
                                   8'h20, 8'hD8})
                wen_ff = 1'b0;
        end
    end
    // Input sampled on rising clock, top bit first
    always @(posedge sclk)
        if (!cs_n && hold_n) begin
            sh_ff = {sh_ff[6:0], mosi};
            nb_ff++;
            if (nb_ff % 8 == 0) last_byte = sh_ff;
            if (nb_ff == 8) begin
                op_ff = sh_ff;
                rd_ff = op_ff inside {8'h03, 8'h0B, 8'h05, 8'h9F, 8'hAB};
                hdr = op_ff == 8'h0B ? 40
                    : op_ff inside {8'h03, 8'hAB} ? 32 : 8;
            end
            if (nb_ff inside {16, 24, 32}) adr_ff = {adr_ff[15:0], sh_ff};
        end
    // Output on falling clock during reads, else a moving pattern
    always @(negedge sclk)
        if (!cs_n && hold_n && rd_ff && nb_ff >= hdr) begin
            k = nb_ff - hdr;
            b = op_ff == 8'h05 ? STAT_VAL : op_ff inside {8'h9F, 8'hAB} ? ID_VAL
                : m(adr_ff[17:0] + 18'(k / 8));
            miso = b[7 - k % 8];
        end else
            miso = ~miso;
endmodule // flash_model
`default_nettype wire

// >>> tb/flash_host_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "flash_host_consts.vh"
module flash_host_test;
    localparam logic [7:0] STAT_VAL = 8'h5A; // Arbitrary
    localparam logic [7:0] ID_VAL   = 8'hA5; // Arbitrary identity value
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic        cs_n_ff, sclk_ff, mosi_ff, miso, wp_n_ff, hold_n_ff;
    int          errors = 0, checks = 0, n, k;
    logic [7:0]  wops[10] = '{8'h06, 8'h04, 8'hB9, 8'h06, 8'hC7, 8'h01,
                              8'h02, 8'hD7, 8'h20, 8'hD8};
    int          wnd[10] = '{0, 0, 0, 0, 0, 1, 3, 0, 0, 0};
    int          wlen[10] = '{1, 1, 1, 1, 1, 2, 7, 4, 4, 4};
    logic        wen_e[10] = '{1, 0, 0, 1, 0, 0, 0, 0, 0, 0};
    logic [7:0]  rops[3] = '{8'h05, 8'h9F, 8'hAB};
    flash_host DUT (.*);
    flash_model FM (.cs_n(cs_n_ff), .sclk(sclk_ff), .mosi(mosi_ff),
                    .hold_n(hold_n_ff), .miso(miso));
    always #12.5 aclk = ~aclk;
    function automatic logic [7:0] m(input logic [17:0] a);
        return a[7:0] ^ {2'b00, a[17:12]};
    endfunction
    task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task summarize;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Bounded clock step
    task step;
        @(posedge aclk);
        n++;
        if (n > 5000) begin
            errors++;
            summarize;
        end
    endtask
    // ------------------------------------------
    // Control bus access
    // ------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            step;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            step;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // Poll busy until the frame is over
    task wait_idle;
        k = 0;
        do begin
            rd(`REG_STATUS);
            k++;
        end while (d[`STAT_BUSY_BIT] !== 1'b0 && k < 400);
        ck("busy", 32'h0, {31'h0, d[`STAT_BUSY_BIT]});
        if (d[`STAT_BUSY_BIT] !== 1'b0)
            summarize;
    endtask
    task frame(input logic [7:0] op, input int nd, input logic m3);
        wr(`REG_CTRL, {7'h00, 9'(nd), op, 6'h00, m3, 1'b1});
        wait_idle;
    endtask
    // ------------------------------------------
    // Scenarios
    // ------------------------------------------
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`REG_DIV);
        ck("div", 32'h1, d);
        // Half period of 4 cycles leaves time for the input synchroniser
        wr(`REG_DIV, 32'h3);
        rd(`REG_DIV);
        ck("div", 32'h3, d);
        rd(`REG_STATUS);
        ck("status", 32'hC, d);
        rd(8'h3C);
        ck("rresp", {30'h0, `BUS_SLVERR}, {30'h0, r});
        wr(8'h3C, 32'h0);
        ck("bresp", {30'h0, `BUS_SLVERR}, {30'h0, r});
        wr(`REG_STATUS, 32'h0);
        ck("pins", 32'h0, {30'h0, wp_n_ff, hold_n_ff});
        wr(`REG_STATUS, 32'hC);
        // Plain read across the top address
        wr(`REG_ADDR, 32'h00FFFFFE);
        frame(`OP_READ, 3, 1'b0);
        rd(`REG_RDATA);
        ck("wrap", {8'h0, m(18'h3FFFE), m(18'h3FFFF), m(18'h0)}, {8'h0, d[23:0]});
        // Fast read in mode 3, suspended in its opcode byte
        wr(`REG_ADDR, 32'h00012345);
        wr(`REG_CTRL, {7'h00, 9'h4, `OP_FAST_READ, 6'h00, 2'b11});
        wr(`REG_STATUS, 32'h4);
        repeat (40) @(posedge aclk);
        rd(`REG_STATUS);
        ck("held", 32'h5, d & 32'hD);
        wr(`REG_STATUS, 32'hC);
        wait_idle;
        rd(`REG_RDATA);
        ck("fast", {m(18'h12345), m(18'h12346), m(18'h12347), m(18'h12348)}, d);
        // Status and identification reads
        for (int i = 0; i < 3; i++) begin
            frame(rops[i], 2, i[0]);
            rd(`REG_RDATA);
            ck("rdop", {2{i == 0 ? STAT_VAL : ID_VAL}}, d[15:0]);
        end
        // Commands framed on byte boundaries
        wr(`REG_WDATA, 32'h44332211);
        for (int i = 0; i < 10; i++) begin
            frame(wops[i], wnd[i], 1'b0);
            ck("op", {24'h0, wops[i]}, {24'h0, FM.last_op});
            ck("wen", {31'h0, wen_e[i]}, {31'h0, FM.wen_ff});
            ck("len", wlen[i], FM.last_nb);
            if (wnd[i] != 0)
                ck("pdata", {24'h0, 8'h11 * 8'(wnd[i])}, {24'h0, FM.last_byte});
        end
        summarize;
    end
endmodule // flash_host_test
`default_nettype wire
